// ==== verilog/uscr_pkg.sv ====
package uscr_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses on the AHB-Lite slave
    // ------------------------------------------------------------------
    localparam logic [7:0] USCR_OFS_RX_STATUS   = 8'h00;
    localparam logic [7:0] USCR_OFS_TX_STATUS   = 8'h04;
    localparam logic [7:0] USCR_OFS_CONTROL     = 8'h08;
    localparam logic [7:0] USCR_OFS_RX_MASK     = 8'h0c;
    localparam logic [7:0] USCR_OFS_TX_MASK     = 8'h10;
    localparam logic [7:0] USCR_OFS_STATION_A   = 8'h14;
    localparam logic [7:0] USCR_OFS_STATION_B   = 8'h18;

    // ------------------------------------------------------------------
    // Receive status bit positions
    // ------------------------------------------------------------------
    localparam int USCR_RX_MARKER_BIT   = 0;
    localparam int USCR_RX_BREAK_BIT    = 1;
    localparam int USCR_RX_PARITY_BIT   = 2;
    localparam int USCR_RX_FRAMING_BIT  = 3;
    localparam int USCR_RX_OVERFLOW_BIT = 4;
    localparam int USCR_RX_HAS_DATA_BIT = 5;
    localparam int USCR_RX_HIT_BIT      = 6;

    // ------------------------------------------------------------------
    // Transmit status bit positions
    // ------------------------------------------------------------------
    localparam int USCR_TX_FULL_BIT     = 0;
    localparam int USCR_TX_ROOM_BIT     = 1;
    localparam int USCR_TX_EMPTY_BIT    = 2;
    localparam int USCR_TX_DONE_BIT     = 3;

    // ------------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------------
    localparam int USCR_CTL_DIR_BIT     = 0;
    localparam int USCR_CTL_BREAK_BIT   = 1;
    localparam int USCR_CTL_MARK_BIT    = 2;
    localparam int USCR_CTL_PAR_LSB     = 3;
    localparam int USCR_CTL_MODE_LSB    = 5;

    // ------------------------------------------------------------------
    // Field encodings and reset values
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        USCR_PAR_NONE  = 2'h0,
        USCR_PAR_EVEN  = 2'h1,
        USCR_PAR_ODD   = 2'h2,
        USCR_PAR_MARK  = 2'h3
    } uscr_parity_e;

    typedef enum logic [2:0] {
        USCR_AM_NONE      = 3'h0,
        USCR_AM_SW_BYTE   = 3'h1,
        USCR_AM_SW_BUFFER = 3'h2,
        USCR_AM_HW_BYTE   = 3'h3,
        USCR_AM_HW_BUFFER = 3'h4
    } uscr_addr_mode_e;

    localparam logic [7:0] USCR_RST_MASK    = 8'h00;
    localparam logic [7:0] USCR_RST_STATION = 8'h00;

    // One received character as handed over by the receive shifter.
    typedef struct packed {
        logic [7:0] data;
        logic       parity;
        logic       stop;
    } uscr_rx_char_s;

endpackage

// ==== verilog/uscr_regs.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Separate receive and transmit status, read-only.
// - Interrupt is OR of masked status bits.
// - Sticky bits hold until status read.
// - Transparent bits follow source, unaffected by read.
// - Status captured on the block clock edge.
// - Sticky marker bit only with address mode.
// - Sticky flag on detected line break.
// - Sticky flag on parity mismatch.
// - Sticky framing flag on low stop bit.
// - Sticky overrun when character meets full FIFO.
// - Transparent flag while receive FIFO holds data.
// - Sticky station match, one address in half-duplex.
// - Transmit FIFO full, not-full, empty flags.
// - Half-duplex omits transmit not-full flag.
// - Sticky flag when last FIFO byte shifted out.
// - Simple build has no control register.
// - Half-duplex direction bit: set transmits, clear receives.
// - Break request drives break onto line.
// - Mark bit gives one mark, then spaces.
// - Two-bit parity type field in control.
// - Parity type from configuration, writable later.
// - Three-bit address mode field, configured, writable.
// - Odd parity accumulator starts at one.
// - Even parity accumulator starts at zero.
// - Hardware modes drop bytes for other stations.
module uscr_regs
    import uscr_pkg::*;
#(
    parameter bit           SIMPLE_BUILD   = 1'b0,
    parameter bit           HALF_DUPLEX    = 1'b0,
    parameter uscr_parity_e INIT_PARITY    = USCR_PAR_NONE,
    parameter logic [2:0]   INIT_ADDR_MODE = 3'h0
)
(
    input  wire logic          hclk,
    input  wire logic          hresetn,
    input  wire logic          ce,
    input  wire logic          hsel,
    input  wire logic [7:0]    haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    input  wire logic          rx_char_valid,
    input  wire uscr_rx_char_s rx_char,
    input  wire logic          rx_line_break,
    input  wire logic          rx_fifo_full,
    input  wire logic          rx_fifo_not_empty,
    output logic               rx_fifo_write,
    input  wire logic          tx_fifo_full,
    input  wire logic          tx_fifo_empty,
    input  wire logic          tx_byte_start,
    input  wire logic [7:0]    tx_byte,
    input  wire logic          tx_byte_shifted,
    output logic               tx_parity_bit,
    output logic               tx_break_out,
    output logic               half_duplex_direction_select,
    output logic [1:0]         parity_type,
    output logic [2:0]         rx_station_filter_mode,
    output logic               rx_interrupt,
    output logic               tx_interrupt
);

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Parity accumulator: seeded by type, toggled on every one bit.
    function automatic logic calc_parity(input logic [7:0] data, input logic odd);
        logic acc;
        acc = odd;
        for (int i = 0; i < 8; i++)
        begin
            acc = acc ^ data[i];
        end
        return acc;
    endfunction

    // Unknown address mode codes behave as no detection.
    function automatic logic [2:0] legal_mode(input logic [2:0] code);
        return (code > USCR_AM_HW_BUFFER) ? USCR_AM_NONE : code;
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        USCR_FLT_IDLE = 2'b00,
        USCR_FLT_PASS = 2'b01,
        USCR_FLT_DROP = 2'b11
    } uscr_filter_e;

    logic                 wr_pend_reg;
    logic [7:0]           wr_addr_reg;
    logic                 addr_phase;
    logic                 rd_take;
    logic                 wr_data;
    logic [7:0]           ctl_reg;
    logic [7:0]           rx_mask_reg;
    logic [7:0]           tx_mask_reg;
    logic [7:0]           station_a_reg;
    logic [7:0]           station_b_reg;
    logic [7:0]           rx_sticky_reg;
    logic [7:0]           rx_sticky_set;
    logic [7:0]           rx_status;
    logic [3:0]           tx_sticky_reg;
    logic [3:0]           tx_sticky_set;
    logic [3:0]           tx_status;
    logic                 rx_has_data_reg;
    logic                 tx_full_reg;
    logic                 tx_empty_reg;
    logic                 rx_clear;
    logic                 tx_clear;
    logic                 mark_prev_reg;
    logic                 mark_armed_reg;
    logic [2:0]           mode_eff;
    logic                 addr_on;
    logic                 hw_filter;
    logic                 is_station_byte;
    logic                 station_match;
    logic                 expected_parity;
    uscr_filter_e         filt_reg;
    uscr_filter_e         filt_next;
    logic                 pass_byte;
    logic [31:0]          rd_mux;

    // ------------------------------------------------------------------
    // AHB-Lite slave
    // ------------------------------------------------------------------

    // Zero wait states; the clock enable stalls the bus while low.
    assign hreadyout  = ce;
    assign hresp      = 1'b0;
    assign addr_phase = ce && hsel && hready && htrans[1];
    assign rd_take    = addr_phase && !hwrite;
    assign wr_data    = ce && wr_pend_reg;

    // Hold a write's address until its data phase.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end
        else if (ce)
        begin
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase)
                wr_addr_reg <= haddr;
        end
    end

    // Read multiplexer; unmapped addresses read zero.
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (haddr)
            USCR_OFS_RX_STATUS: rd_mux[7:0] = rx_status;
            USCR_OFS_TX_STATUS: rd_mux[3:0] = tx_status;
            USCR_OFS_CONTROL:   rd_mux[7:0] = SIMPLE_BUILD ? 8'h00 : ctl_reg;
            USCR_OFS_RX_MASK:   rd_mux[7:0] = rx_mask_reg;
            USCR_OFS_TX_MASK:   rd_mux[7:0] = tx_mask_reg;
            USCR_OFS_STATION_A: rd_mux[7:0] = station_a_reg;
            USCR_OFS_STATION_B: rd_mux[7:0] = station_b_reg;
            default:            rd_mux = 32'h0000_0000;
        endcase
    end

    // Read data is registered at the address phase edge.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata <= 32'h0000_0000;
        else if (rd_take)
            hrdata <= rd_mux;
    end

    // A status read clears its sticky bits at the same edge.
    assign rx_clear = rd_take && (haddr == USCR_OFS_RX_STATUS);
    assign tx_clear = rd_take && (haddr == USCR_OFS_TX_STATUS);

    // ------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------

    // Masks and station addresses; status offsets ignore writes.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_mask_reg   <= USCR_RST_MASK;
            tx_mask_reg   <= USCR_RST_MASK;
            station_a_reg <= USCR_RST_STATION;
            station_b_reg <= USCR_RST_STATION;
        end
        else if (wr_data)
        begin
            if (wr_addr_reg == USCR_OFS_RX_MASK)
                rx_mask_reg <= hwdata[7:0];
            if (wr_addr_reg == USCR_OFS_TX_MASK)
                tx_mask_reg <= hwdata[7:0];
            if (wr_addr_reg == USCR_OFS_STATION_A)
                station_a_reg <= hwdata[7:0];
            if (wr_addr_reg == USCR_OFS_STATION_B)
                station_b_reg <= hwdata[7:0];
        end
    end

    // Control register, loaded from configuration at reset.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            ctl_reg <= {INIT_ADDR_MODE, INIT_PARITY, 3'h0};
        else if (wr_data && !SIMPLE_BUILD && (wr_addr_reg == USCR_OFS_CONTROL))
            ctl_reg <= hwdata[7:0];
    end

    // Control fields fanned out to the line logic.
    assign half_duplex_direction_select = HALF_DUPLEX && ctl_reg[USCR_CTL_DIR_BIT];
    assign tx_break_out                 = ctl_reg[USCR_CTL_BREAK_BIT];
    assign parity_type                  = ctl_reg[USCR_CTL_PAR_LSB +: 2];
    assign mode_eff                     = legal_mode(ctl_reg[USCR_CTL_MODE_LSB +: 3]);
    assign rx_station_filter_mode       = mode_eff;
    assign addr_on                      = (mode_eff != USCR_AM_NONE);
    assign hw_filter                    = (mode_eff == USCR_AM_HW_BYTE) || (mode_eff == USCR_AM_HW_BUFFER);

    // ------------------------------------------------------------------
    // Receive checks and station filter
    // ------------------------------------------------------------------

    // A set parity position marks a station byte.
    assign is_station_byte = rx_char.parity;
    assign station_match   = (rx_char.data == station_a_reg) ||
                             (!HALF_DUPLEX && (rx_char.data == station_b_reg));
    assign expected_parity = calc_parity(rx_char.data, parity_type == USCR_PAR_ODD);

    // Packet filter: follow our station, drop the others.
    always_comb
    begin
        filt_next = filt_reg;
        pass_byte = 1'b1;
        if (rx_char_valid && hw_filter)
        begin
            if (is_station_byte)
            begin
                filt_next = station_match ? USCR_FLT_PASS : USCR_FLT_DROP;
                pass_byte = station_match && (mode_eff == USCR_AM_HW_BYTE);
            end
            else
            begin
                pass_byte = (filt_reg == USCR_FLT_PASS);
            end
        end
        else if (!hw_filter)
        begin
            filt_next = USCR_FLT_IDLE;
        end
    end

    // Filter state register.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            filt_reg <= USCR_FLT_IDLE;
        else if (ce)
            filt_reg <= filt_next;
    end

    // Accepted characters go to the receive FIFO.
    assign rx_fifo_write = ce && rx_char_valid && !rx_fifo_full && pass_byte;

    // Receive sticky sources.
    always_comb
    begin
        rx_sticky_set                       = 8'h00;
        rx_sticky_set[USCR_RX_MARKER_BIT]   = rx_char_valid && addr_on && rx_char.parity;
        rx_sticky_set[USCR_RX_BREAK_BIT]    = rx_line_break;
        rx_sticky_set[USCR_RX_PARITY_BIT]   = rx_char_valid &&
                                              ((parity_type == USCR_PAR_EVEN) || (parity_type == USCR_PAR_ODD)) &&
                                              (rx_char.parity != expected_parity);
        rx_sticky_set[USCR_RX_FRAMING_BIT]  = rx_char_valid && !rx_char.stop;
        rx_sticky_set[USCR_RX_OVERFLOW_BIT] = rx_char_valid && rx_fifo_full;
        rx_sticky_set[USCR_RX_HIT_BIT]      = rx_char_valid && addr_on && is_station_byte &&
                                              station_match;
    end

    // Transmit sticky source: last byte out with the FIFO empty.
    always_comb
    begin
        tx_sticky_set                   = 4'h0;
        tx_sticky_set[USCR_TX_DONE_BIT] = tx_byte_shifted && tx_fifo_empty;
    end

    // ------------------------------------------------------------------
    // Status registers
    // ------------------------------------------------------------------

    // Sticky bits: a new event wins over a clearing read.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_sticky_reg <= 8'h00;
            tx_sticky_reg <= 4'h0;
        end
        else if (ce)
        begin
            rx_sticky_reg <= (rx_sticky_reg & {8{!rx_clear}}) | rx_sticky_set;
            tx_sticky_reg <= (tx_sticky_reg & {4{!tx_clear}}) | tx_sticky_set;
        end
    end

    // Transparent bits track their sources; reads leave them alone.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rx_has_data_reg <= 1'b0;
            tx_full_reg     <= 1'b0;
            tx_empty_reg    <= 1'b1;
        end
        else if (ce)
        begin
            rx_has_data_reg <= rx_fifo_not_empty;
            tx_full_reg     <= tx_fifo_full;
            tx_empty_reg    <= tx_fifo_empty;
        end
    end

    // Assemble the visible status words.
    always_comb
    begin
        rx_status                       = rx_sticky_reg;
        rx_status[USCR_RX_MARKER_BIT]   = addr_on && rx_sticky_reg[USCR_RX_MARKER_BIT];
        rx_status[USCR_RX_HIT_BIT]      = addr_on && rx_sticky_reg[USCR_RX_HIT_BIT];
        rx_status[USCR_RX_HAS_DATA_BIT] = rx_has_data_reg;
        rx_status[7]                    = 1'b0;
        tx_status                       = tx_sticky_reg;
        tx_status[USCR_TX_FULL_BIT]     = tx_full_reg;
        tx_status[USCR_TX_ROOM_BIT]     = !HALF_DUPLEX && !tx_full_reg;
        tx_status[USCR_TX_EMPTY_BIT]    = tx_empty_reg;
    end

    // Interrupts: OR of status bits gated by their masks.
    assign rx_interrupt = |(rx_status & rx_mask_reg);
    assign tx_interrupt = |(tx_status & tx_mask_reg[3:0]);

    // ------------------------------------------------------------------
    // Transmit parity generation
    // ------------------------------------------------------------------

    // A rising mark bit arms one mark; the next byte consumes it.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mark_prev_reg  <= 1'b0;
            mark_armed_reg <= 1'b0;
        end
        else if (ce)
        begin
            mark_prev_reg <= ctl_reg[USCR_CTL_MARK_BIT];
            if (ctl_reg[USCR_CTL_MARK_BIT] && !mark_prev_reg)
                mark_armed_reg <= 1'b1;
            else if (tx_byte_start)
                mark_armed_reg <= 1'b0;
        end
    end

    // Parity position value latched at each byte start.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tx_parity_bit <= 1'b0;
        else if (ce && tx_byte_start)
        begin
            unique case (parity_type)
                USCR_PAR_NONE: tx_parity_bit <= 1'b0;
                USCR_PAR_EVEN: tx_parity_bit <= calc_parity(tx_byte, 1'b0);
                USCR_PAR_ODD:  tx_parity_bit <= calc_parity(tx_byte, 1'b1);
                USCR_PAR_MARK: tx_parity_bit <= mark_armed_reg;
            endcase
        end
    end

endmodule // uscr_regs

// ==== verification/uscr_regs_assertions.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Port checker for the status and control registers
// ------------------------------------------------------------------
module uscr_regs_checker
    import uscr_pkg::*;
(
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       ce,
    input wire logic       hreadyout,
    input wire logic       hresp,
    input wire logic       rx_char_valid,
    input wire logic       rx_fifo_full,
    input wire logic       rx_fifo_write,
    input wire logic       tx_byte_start,
    input wire logic [7:0] tx_byte,
    input wire logic       tx_parity_bit,
    input wire logic [1:0] parity_type,
    input wire logic [2:0] rx_station_filter_mode,
    input wire logic       rx_interrupt,
    input wire logic       tx_interrupt
);
    // Every check samples on the bus clock and rests during reset.
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ready_follows_ce_a: assert property (hreadyout == ce) else $error("hreadyout differs from ce");
    resp_okay_a: assert property (hresp == 1'b0) else $error("hresp not OKAY");
    fifo_write_gate_a: assert property (rx_fifo_write |-> ce && rx_char_valid && !rx_fifo_full)
        else $error("receive FIFO written without a free slot");
    open_filter_pass_a: assert property (ce && rx_char_valid && !rx_fifo_full
        && rx_station_filter_mode inside {3'h0, 3'h1, 3'h2} |-> rx_fifo_write) else $error("character lost");
    mode_code_legal_a: assert property (rx_station_filter_mode <= 3'h4) else $error("illegal mode shown");
    odd_parity_bit_a: assert property (ce && tx_byte_start && parity_type == USCR_PAR_ODD
        |=> tx_parity_bit == ~^$past(tx_byte)) else $error("odd parity bit wrong");
    even_parity_bit_a: assert property (ce && tx_byte_start && parity_type == USCR_PAR_EVEN
        |=> tx_parity_bit == ^$past(tx_byte)) else $error("even parity bit wrong");
    parity_bit_hold_a: assert property (!(ce && tx_byte_start) |=> $stable(tx_parity_bit))
        else $error("parity bit moved without a byte");
    ce_freeze_a: assert property (!ce |=> $stable(parity_type) && $stable(rx_interrupt) && $stable(tx_interrupt))
        else $error("state moved while ce low");

    // Main scenarios seen.
    cover property (rx_fifo_write);
    cover property ($rose(tx_interrupt));
    cover property (ce && tx_byte_start && parity_type == USCR_PAR_MARK);
endmodule // uscr_regs_checker

bind uscr_regs uscr_regs_checker u_chk (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hreadyout(hreadyout),
    .hresp(hresp), .rx_char_valid(rx_char_valid), .rx_fifo_full(rx_fifo_full), .rx_fifo_write(rx_fifo_write),
    .tx_byte_start(tx_byte_start), .tx_byte(tx_byte), .tx_parity_bit(tx_parity_bit), .parity_type(parity_type),
    .rx_station_filter_mode(rx_station_filter_mode), .rx_interrupt(rx_interrupt), .tx_interrupt(tx_interrupt));

// ==== verification/testbench.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------------
// Self-checking bench for the status and control registers
// ------------------------------------------------------------------
module testbench
    import uscr_pkg::*;
;
    logic          hclk = 1'b0, hresetn = 1'b0, ce = 1'b1, hsel = 1'b0, hwrite = 1'b0;
    logic [7:0]    haddr = 8'h00, tx_byte = 8'h00, sta, stb, ctl, rmask, exp8;
    logic [1:0]    htrans = 2'h0, parity_type;
    logic [31:0]   hwdata = 32'h0, hrdata, rd, j;
    logic          rx_char_valid = 1'b0, rx_line_break = 1'b0, rx_fifo_full = 1'b0, rx_fifo_not_empty = 1'b0;
    logic          tx_fifo_full = 1'b0, tx_fifo_empty = 1'b1, tx_byte_start = 1'b0, tx_byte_shifted = 1'b0;
    logic          hreadyout, hresp, rx_fifo_write, tx_parity_bit, tx_break_out, hd_dir, rx_int, tx_int;
    logic [2:0]    filt_mode;
    uscr_rx_char_s rx_char = '0, c;
    integer        seed = 43237, err_count = 0, checks_done = 0, i, k;

    uscr_regs #(.INIT_PARITY(USCR_PAR_ODD), .INIT_ADDR_MODE(3'h3)) u_uscr_regs (.hclk(hclk), .hresetn(hresetn),
        .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .rx_line_break(rx_line_break), .rx_fifo_full(rx_fifo_full),
        .rx_fifo_not_empty(rx_fifo_not_empty), .rx_fifo_write(rx_fifo_write), .tx_fifo_full(tx_fifo_full),
        .tx_fifo_empty(tx_fifo_empty), .tx_byte_start(tx_byte_start), .tx_byte(tx_byte),
        .tx_byte_shifted(tx_byte_shifted), .tx_parity_bit(tx_parity_bit), .tx_break_out(tx_break_out),
        .half_duplex_direction_select(hd_dir), .parity_type(parity_type), .rx_station_filter_mode(filt_mode),
        .rx_interrupt(rx_int), .tx_interrupt(tx_int));

    // Free-running 200 MHz clock.
    initial
        forever #2.5 hclk = ~hclk;

    task close_out;
        if (err_count == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One AHB-Lite single transfer; read data lands in rd.
    task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // One received character, with the FIFO write checked in its cycle.
    task ev(input uscr_rx_char_s ch, input logic full, input logic brk, input logic pass);
        rx_char <= ch;
        rx_fifo_full <= full;
        rx_line_break <= brk;
        rx_char_valid <= 1'b1;
        #1;
        chk({31'h0, rx_fifo_write}, {31'h0, pass});
        @(posedge hclk);
        rx_char_valid <= 1'b0;
        rx_line_break <= 1'b0;
        @(posedge hclk);
    endtask

    // One transmitted byte and its parity bit.
    task txb(input logic [7:0] b, input logic e);
        tx_byte <= b;
        tx_byte_start <= 1'b1;
        @(posedge hclk);
        tx_byte_start <= 1'b0;
        @(posedge hclk);
        chk({31'h0, tx_parity_bit}, {31'h0, e});
    endtask

    function automatic logic [7:0] rx_exp(input uscr_rx_char_s ch, input logic [4:0] f, input logic on);
        rx_exp = {1'b0, on & (ch.data == sta || ch.data == stb), f[4], f[2], ~ch.stop, ch.parity ^ (^ch.data),
                  f[3], on & ch.parity};
    endfunction

    // Main sequence.
    initial
    begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        rdc(USCR_OFS_CONTROL, 32'h70);
        rdc(USCR_OFS_TX_STATUS, 32'h06);
        rdc(USCR_OFS_RX_MASK, 32'h0);
        bus(1'b1, USCR_OFS_RX_STATUS, 32'hff);
        bus(1'b1, 8'h1c, 32'h5a);
        rdc(USCR_OFS_RX_STATUS, 32'h0);
        rdc(8'h1c, 32'h0);
        sta = 8'($random(seed));
        stb = sta ^ 8'h80;
        bus(1'b1, USCR_OFS_STATION_A, {24'h0, sta});
        bus(1'b1, USCR_OFS_STATION_B, {24'h0, stb});
        for (i = 3; i <= 4; i++)
        begin
            bus(1'b1, USCR_OFS_CONTROL, {24'h0, i[2:0], USCR_PAR_MARK, 3'h0});
            ev({sta ^ 8'h01, 2'b11}, 1'b0, 1'b0, 1'b0);
            ev({8'h55, 2'b01}, 1'b0, 1'b0, 1'b0);
            ev({sta, 2'b11}, 1'b0, 1'b0, i == 3);
            ev({8'h55, 2'b01}, 1'b0, 1'b0, 1'b1);
        end
        rmask = 8'($random(seed));
        bus(1'b1, USCR_OFS_RX_MASK, {24'h0, rmask});
        bus(1'b0, USCR_OFS_RX_STATUS, 32'h0);
        for (i = 0; i < 24; i++)
        begin
            bus(1'b1, USCR_OFS_CONTROL, {24'h0, 2'b00, i[0], USCR_PAR_EVEN, 3'h0});
            c = 10'($random(seed));
            j = $random(seed);
            if (j[1:0] == 2'h0)
                c.data = sta;
            if (j[1:0] == 2'h1)
                c.data = stb;
            if (c.data == sta || c.data == stb)
                c.parity = 1'b1;
            rx_fifo_not_empty <= j[4];
            ev(c, j[2], j[3], !j[2]);
            exp8 = rx_exp(c, j[4:0], i[0]);
            chk({31'h0, rx_int}, {31'h0, |(exp8 & rmask)});
            rdc(USCR_OFS_RX_STATUS, {24'h0, exp8});
            rdc(USCR_OFS_RX_STATUS, {24'h0, exp8 & 8'h20});
            chk({31'h0, rx_int}, {31'h0, |(exp8 & 8'h20 & rmask)});
        end
        bus(1'b1, USCR_OFS_TX_MASK, 32'h08);
        for (i = 0; i < 6; i++)
        begin
            j = $random(seed);
            tx_fifo_full <= j[0] & ~j[1];
            tx_fifo_empty <= j[1];
            tx_byte_shifted <= j[1];
            @(posedge hclk);
            tx_byte_shifted <= 1'b0;
            @(posedge hclk);
            exp8 = {4'h0, j[1], j[1], ~(j[0] & ~j[1]), j[0] & ~j[1]};
            chk({31'h0, tx_int}, {31'h0, j[1]});
            rdc(USCR_OFS_TX_STATUS, {24'h0, exp8});
            rdc(USCR_OFS_TX_STATUS, {24'h0, exp8 & 8'h07});
        end
        for (i = 0; i < 8; i++)
        begin
            j = $random(seed);
            ctl = {i[2:0], i[1:0], 1'b0, j[1:0]};
            bus(1'b1, USCR_OFS_CONTROL, {24'h0, ctl});
            @(posedge hclk);
            chk({29'h0, filt_mode}, {29'h0, (i < 5) ? i[2:0] : 3'h0});
            chk({30'h0, parity_type}, {30'h0, i[1:0]});
            chk({30'h0, tx_break_out, hd_dir}, {30'h0, ctl[1], 1'b0});
            if (i < 5)
                rdc(USCR_OFS_CONTROL, {24'h0, ctl});
        end
        ce <= 1'b0;
        repeat (2) @(posedge hclk);
        ce <= 1'b1;
        for (i = 1; i <= 2; i++)
        begin
            bus(1'b1, USCR_OFS_CONTROL, {24'h0, 3'h0, i[1:0], 3'h0});
            for (k = 0; k < 4; k++)
            begin
                ctl = 8'($random(seed));
                txb(ctl, (i == 2) ^ (^ctl));
            end
        end
        for (i = 0; i < 2; i++)
        begin
            bus(1'b1, USCR_OFS_CONTROL, 32'h18);
            bus(1'b1, USCR_OFS_CONTROL, 32'h1c);
            @(posedge hclk);
            txb(8'($random(seed)), 1'b1);
            txb(8'($random(seed)), 1'b0);
        end
        close_out;
    end

    // Cuts a hung run short.
    initial
    begin
        #100000;
        err_count = err_count + 1;
        close_out;
    end
endmodule // testbench
